/* File: verilog/frt_timer.sv */
// Free-running 16-bit timer counter with Wishbone register access
module frt_timer (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone classic slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [4:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // System
  input  wire logic        ext_clk_i,
  input  wire logic        core_int_mask_i,
  input  wire logic        halt_i,
  output logic      [15:0] count_o,
  output logic             overflow_irq_o
);
  typedef struct packed {
    logic [15:0] count;
    logic [2:0]  presc;
    logic [7:0]  low_hold;
    logic        hold_valid;
    logic        overflow_flag;
    logic        clear_armed;
    logic        overflow_interrupt_enable;
    logic [1:0]  timer_clock_select;
    logic        ack;
    logic [31:0] rdata;
    logic        irq;
  } frt_state_s;

  frt_state_s st;
  frt_state_s next_st;
  logic       ext_rise;

  //==========================================================================
  // External clock qualification
  frt_edge_sync u_ext_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (ext_clk_i),
    .rise_o  (ext_rise)
  );

  //==========================================================================
  // Bus decode
  logic       acc;
  logic       rd;
  logic       wr;
  logic       lane0;
  logic [2:0] last_presc;
  logic       tick;
  logic       overflow_evt;

  // One access per request; ack drops the cycle after it was given
  assign acc   = cyc_i & stb_i & ~st.ack;
  assign rd    = acc & ~we_i;
  assign wr    = acc & we_i;
  assign lane0 = sel_i[0];

  //==========================================================================
  // Prescaler terminal count per clock select
  always_comb begin
    unique case (frt_pkg::frt_clksel_e'(st.timer_clock_select))
      frt_pkg::FRT_CLK_DIV2: last_presc = frt_pkg::FRT_DIV2_LAST;
      frt_pkg::FRT_CLK_DIV4: last_presc = frt_pkg::FRT_DIV4_LAST;
      frt_pkg::FRT_CLK_DIV8: last_presc = frt_pkg::FRT_DIV8_LAST;
      frt_pkg::FRT_CLK_EXT:  last_presc = frt_pkg::FRT_DIV2_LAST;
    endcase
  end

  // Tick source: divided clock or qualified external edge; halt freezes all
  assign tick = ~halt_i &
                ((st.timer_clock_select == frt_pkg::FRT_CLK_EXT) ? ext_rise
                                                                 : (st.presc == last_presc));
  assign overflow_evt = tick & (st.count == frt_pkg::FRT_COUNT_MAX);

  //==========================================================================
  // Next-state logic
  always_comb begin
    next_st     = st;
    next_st.ack = acc;

    // Prescaler runs unless halted; a wrap of the select keeps it in range
    if (!halt_i) begin
      next_st.presc = (st.presc >= last_presc) ? 3'h0 : st.presc + 3'h1;
    end

    if (tick) begin
      next_st.count = st.count + 16'h0001;
    end

    // Low byte write restarts counter and prescaler
    if (wr && lane0 && (adr_i == frt_pkg::FRT_COUNT_LOW_BYTE_OFS ||
                        adr_i == frt_pkg::FRT_ALT_COUNT_LOW_BYTE_OFS)) begin
      next_st.count = frt_pkg::FRT_COUNT_RESET;
      next_st.presc = 3'h0;
    end

    // Control writes
    if (wr && lane0 && adr_i == frt_pkg::FRT_CONTROL_ONE_OFS) begin
      next_st.overflow_interrupt_enable = dat_i[frt_pkg::FRT_CTL1_OVF_IE_BIT];
    end
    if (wr && lane0 && adr_i == frt_pkg::FRT_CONTROL_TWO_OFS) begin
      next_st.timer_clock_select = dat_i[frt_pkg::FRT_CTL2_CLKSEL_LSB +: 2];
    end

    // Read data and high-then-low buffering
    next_st.rdata = 32'h0000_0000;
    if (rd) begin
      unique case (adr_i)
        frt_pkg::FRT_COUNT_HIGH_BYTE_OFS,
        frt_pkg::FRT_ALT_COUNT_HIGH_BYTE_OFS: begin
          next_st.rdata[7:0] = st.count[15:8];
          if (!st.hold_valid) begin
            next_st.low_hold   = st.count[7:0];
            next_st.hold_valid = 1'b1;
          end
        end
        frt_pkg::FRT_COUNT_LOW_BYTE_OFS,
        frt_pkg::FRT_ALT_COUNT_LOW_BYTE_OFS: begin
          next_st.rdata[7:0] = st.hold_valid ? st.low_hold
                                             : st.count[7:0];
          next_st.hold_valid = 1'b0;
        end
        frt_pkg::FRT_STATUS_OFS: begin
          next_st.rdata[frt_pkg::FRT_STATUS_OVF_BIT] = st.overflow_flag;
          if (st.overflow_flag) begin
            next_st.clear_armed = 1'b1;
          end
        end
        frt_pkg::FRT_CONTROL_ONE_OFS: begin
          next_st.rdata[frt_pkg::FRT_CTL1_OVF_IE_BIT] = st.overflow_interrupt_enable;
        end
        frt_pkg::FRT_CONTROL_TWO_OFS: begin
          next_st.rdata[frt_pkg::FRT_CTL2_CLKSEL_LSB +: 2] = st.timer_clock_select;
        end
        default: begin
          next_st.rdata = 32'h0000_0000;  // Unmapped reads as zero
        end
      endcase
    end

    // Second step of the clear: main low byte access only, never alternate
    if (acc && st.clear_armed && adr_i == frt_pkg::FRT_COUNT_LOW_BYTE_OFS) begin
      next_st.overflow_flag = 1'b0;
      next_st.clear_armed   = 1'b0;
    end

    // A rollover in the clearing cycle wins over the clear
    if (overflow_evt) begin
      next_st.overflow_flag = 1'b1;
    end

    // Request level stays pending while enable or mask block it
    next_st.irq = next_st.overflow_flag & next_st.overflow_interrupt_enable
                  & ~core_int_mask_i;
  end

  //==========================================================================
  // State register; reset also serves as wake-from-halt reload
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st                    <= '0;
      st.count              <= frt_pkg::FRT_COUNT_RESET;
      st.timer_clock_select <= frt_pkg::FRT_CLKSEL_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign dat_o          = st.rdata;
  assign ack_o          = st.ack;
  assign count_o        = st.count;
  assign overflow_irq_o = st.irq;
endmodule : frt_timer

/* File: verilog/frt_pkg.sv */
// Constants, register map and field layout of the free-running timer counter
//==========================================================================
package frt_pkg;
  //==========================================================================
  // Register word addresses (byte offsets on the bus)
  localparam logic [4:0] FRT_COUNT_HIGH_BYTE_OFS     = 5'h00;
  localparam logic [4:0] FRT_COUNT_LOW_BYTE_OFS      = 5'h04;
  localparam logic [4:0] FRT_ALT_COUNT_HIGH_BYTE_OFS = 5'h08;
  localparam logic [4:0] FRT_ALT_COUNT_LOW_BYTE_OFS  = 5'h0c;
  localparam logic [4:0] FRT_STATUS_OFS              = 5'h10;
  localparam logic [4:0] FRT_CONTROL_ONE_OFS         = 5'h14;
  localparam logic [4:0] FRT_CONTROL_TWO_OFS         = 5'h18;

  //==========================================================================
  // Field positions
  localparam int FRT_STATUS_OVF_BIT  = 5;  // Overflow flag in status
  localparam int FRT_CTL1_OVF_IE_BIT = 5;  // Overflow interrupt enable
  localparam int FRT_CTL2_CLKSEL_LSB = 0;  // Timer clock select, 2 bits

  //==========================================================================
  // Reset values and count maximum
  localparam logic [15:0] FRT_COUNT_RESET = 16'hfffc;
  localparam logic [15:0] FRT_COUNT_MAX   = 16'hffff;
  localparam logic [1:0]  FRT_CLKSEL_RESET = 2'h0;

  // Timer clock select encodings
  typedef enum logic [1:0] {
    FRT_CLK_DIV2 = 2'b00,
    FRT_CLK_DIV4 = 2'b01,
    FRT_CLK_DIV8 = 2'b10,
    FRT_CLK_EXT  = 2'b11
  } frt_clksel_e;

  // Prescaler division minus one for each internal factor
  localparam logic [2:0] FRT_DIV2_LAST = 3'h1;
  localparam logic [2:0] FRT_DIV4_LAST = 3'h3;
  localparam logic [2:0] FRT_DIV8_LAST = 3'h7;
endpackage : frt_pkg

/* File: verilog/frt_edge_sync.sv */
// Two-flop synchroniser with rising edge detect for the external timer clock
module frt_edge_sync (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic async_i,
  output logic      rise_o
);
  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
    logic rise;
  } frt_sync_s;

  frt_sync_s st;
  frt_sync_s next_st;

  //==========================================================================
  // First flop only feeds the second; edge taken past the second
  always_comb begin
    next_st      = st;
    next_st.meta = async_i;
    next_st.sync = st.meta;
    next_st.last = st.sync;
    next_st.rise = st.sync & ~st.last;
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rise_o = st.rise;
endmodule : frt_edge_sync

/* File: verification/frt_timer_assertions.sv */
// Port-level checker for the free-running timer counter
module frt_timer_assertions (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [4:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        ext_clk_i,
  input wire logic        core_int_mask_i,
  input wire logic        halt_i,
  input wire logic [15:0] count_o,
  input wire logic        overflow_irq_o
);
  //==========================================================================
  // Assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic req;
  // Request taken this edge
  assign req = cyc_i && stb_i && !ack_o;
  chk_ack_answer: assert property (req |=> ack_o ##1 !ack_o) else $error("ack not a single pulse");
  chk_count_step: assert property ($changed(count_o) |-> count_o == $past(count_o) + 16'h1
    || count_o == 16'hfffc) else $error("count moved by other than one");
  chk_tick_gap: assert property ($changed(count_o) && count_o != 16'hfffc && !req |=> $stable(count_o))
    else $error("two ticks in a row");
  chk_reset_load: assert property (disable iff (1'b0) rst_i |=> count_o == 16'hfffc)
    else $error("reset did not load count");
  chk_low_restart: assert property (req && we_i && sel_i[0] && (adr_i == 5'h04 || adr_i == 5'h0c)
    |=> count_o == 16'hfffc) else $error("low byte write did not restart");
  chk_halt_hold: assert property (halt_i && !req |=> $stable(count_o))
    else $error("count moved in halt");
  chk_irq_masked: assert property (overflow_irq_o |-> !$past(core_int_mask_i))
    else $error("irq while masked");
  // Only an access taken or core_int_mask_i set at this edge may drop the request at the next one
  chk_irq_pending: assert property (overflow_irq_o && !core_int_mask_i && !req |=> overflow_irq_o)
    else $error("irq dropped without access");
  chk_unmapped_zero: assert property (req && !we_i && adr_i > 5'h18 |=> dat_o == 32'h0)
    else $error("unmapped read not zero");
  cov_rollover: cover property ($past(count_o) == 16'hffff && count_o == 16'h0);
  cov_halt: cover property (halt_i && !req);
  cov_irq: cover property ($rose(overflow_irq_o));
endmodule : frt_timer_assertions

bind frt_timer frt_timer_assertions u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
  .ext_clk_i(ext_clk_i), .core_int_mask_i(core_int_mask_i), .halt_i(halt_i), .count_o(count_o),
  .overflow_irq_o(overflow_irq_o));

/* File: verification/frt_cpu_model.sv */
// Wishbone master model of the CPU core
module frt_cpu_model (
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic [31:0] rd_i,
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic      [4:0]  adr_o,
  output logic      [3:0]  sel_o,
  output logic      [31:0] wd_o,
  output logic             tmo_o
);
  timeunit 1ns;
  timeprecision 1ns;
  //==========================================================================
  // Bus cycles
  initial begin
    {cyc_o, stb_o, we_o, adr_o, sel_o, wd_o, tmo_o} = '0;
  end
  // One classic cycle; some callers read a low byte with no high byte read before it
  task automatic xfer(input logic w, input logic [4:0] a, input logic [7:0] d, output logic [31:0] q);
    int n;
    @(posedge clk_i);
    {cyc_o, stb_o, we_o, adr_o, sel_o, wd_o} <= {2'b11, w, a, 4'h1, 24'h0, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_i !== 1'b1 && n < 20);
    q = rd_i;
    tmo_o = (ack_i !== 1'b1);
    // Released address and write data show the inverse so stale values cannot match
    {cyc_o, stb_o, adr_o, wd_o} <= {2'b00, ~a, ~wd_o};
  endtask : xfer
endmodule : frt_cpu_model

/* File: verification/frt_timer_tb.sv */
// Self-checking bench of the free-running timer counter
module frt_timer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        ext = 1'b0;
  logic        mask = 1'b1;
  logic        halt = 1'b0;
  logic        cyc, stb, we, ack, irq, tmo;
  logic [4:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wd, rd, q;
  logic [15:0] cnt;
  int          error_cnt = 0;
  int          checked = 0;
  //==========================================================================
  // Clock, parts and helpers
  always #50 clk_i = ~clk_i;
  frt_timer dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(wd), .dat_o(rd), .ack_o(ack), .ext_clk_i(ext), .core_int_mask_i(mask),
    .halt_i(halt), .count_o(cnt), .overflow_irq_o(irq));
  frt_cpu_model cpu (.clk_i(clk_i), .ack_i(ack), .rd_i(rd), .cyc_o(cyc), .stb_o(stb), .we_o(we),
    .adr_o(adr), .sel_o(sel), .wd_o(wd), .tmo_o(tmo));
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // Missing ack ends the run at once
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    cpu.xfer(w, a, d, q);
    if (tmo !== 1'b0) begin
      error_cnt++;
      test_done();
    end
  endtask : bus
  task automatic rdc(input logic [4:0] a, input logic [7:0] e, input string nm);
    bus(1'b0, a, 8'h00);
    chk(nm, q, {24'h0, e});
  endtask : rdc
  //==========================================================================
  // Scenarios
  task automatic t_hold();
    @(posedge clk_i);
    halt <= 1'b1;
    bus(1'b1, 5'h04, 8'h5a);
    rdc(5'h00, 8'hff, "count_high");
    rdc(5'h08, 8'hff, "alt_high");
    @(posedge clk_i);
    halt <= 1'b0;
    repeat (3) @(posedge clk_i);
    halt <= 1'b1;
    rdc(5'h08, 8'hff, "alt_high_again");
    rdc(5'h0c, 8'hfc, "held_low");
    rdc(5'h04, 8'hfd, "live_low");
    chk("count_halted", {16'h0, cnt}, 32'hfffd);
  endtask : t_hold
  // Ticks come N clocks after a restart for each divider
  task automatic t_div();
    int n;
    @(posedge clk_i);
    halt <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      bus(1'b1, 5'h18, 8'(k));
      bus(1'b1, 5'h04, 8'h00);
      #1;
      n = 1;
      while (cnt === 16'hfffc && n < 20) begin
        @(posedge clk_i);
        #1;
        n++;
      end
      chk("tick_gap", n, 2 << k);
    end
  endtask : t_div
  task automatic t_ext();
    bus(1'b1, 5'h18, 8'h03);
    bus(1'b1, 5'h0c, 8'h00);
    repeat (3) begin
      repeat (5) @(posedge clk_i);
      ext <= 1'b1;
      repeat (5) @(posedge clk_i);
      ext <= 1'b0;
    end
    repeat (5) @(posedge clk_i);
    chk("ext_count", {16'h0, cnt}, 32'hffff);
  endtask : t_ext
  task automatic t_ovf();
    bus(1'b1, 5'h18, 8'h00);
    bus(1'b1, 5'h14, 8'h20);
    rdc(5'h14, 8'h20, "ctl_one");
    rdc(5'h1c, 8'h00, "unmapped");
    bus(1'b1, 5'h04, 8'h00);
    repeat (12) @(posedge clk_i);
    chk("irq_masked", irq, 1'b0);
    // Main low read before any status read must leave the flag alone
    bus(1'b0, 5'h04, 8'h00);
    rdc(5'h10, 8'h20, "flag_set");
    bus(1'b0, 5'h0c, 8'h00);
    mask <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk("irq_unmasked", irq, 1'b1);
    rdc(5'h10, 8'h20, "flag_after_alt");
    bus(1'b0, 5'h04, 8'h00);
    rdc(5'h10, 8'h00, "flag_cleared");
    repeat (2) @(posedge clk_i);
    chk("irq_cleared", irq, 1'b0);
  endtask : t_ovf
  // Reset during halt reloads the count
  task automatic t_reset();
    halt <= 1'b1;
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    #1;
    chk("count_reload", {16'h0, cnt}, 32'hfffc);
    rdc(5'h14, 8'h00, "ctl_one_reset");
  endtask : t_reset
  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_hold();
    t_div();
    t_ext();
    t_ovf();
    t_reset();
    test_done();
  end
endmodule : frt_timer_tb
